// [src/seq_pkg.sv]
// Constants and types shared by the acquisition set sequencer.
package seq_pkg;
   localparam int SET_COUNT = 8;
   localparam int SET_W     = 3;
   localparam int VAL_W     = 16;
   localparam int ADDR_W    = 8;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FEATURE  = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_SELECT   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_SET_CMD  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PATH     = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_FIRST    = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_EXPOSURE = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_GAIN     = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_IMPLIED  = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_FIXED    = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_AUTO     = 8'h2C;

   // Field positions.
   localparam int CTRL_RUN_BIT    = 0;
   localparam int CTRL_CFG_BIT    = 1;
   localparam int STAT_OK_BIT     = 0;
   localparam int STAT_RUN_BIT    = 1;
   localparam int STAT_CFG_BIT    = 2;
   localparam int STAT_SET_LSB    = 4;
   localparam int STAT_SETOK_BIT  = 8;
   localparam int FEAT_ON_BIT     = 8;
   localparam int SEL_PATH_LSB    = 8;
   localparam int CMD_STORE_BIT   = 0;
   localparam int CMD_RESTORE_BIT = 1;
   localparam int PATH_EDGE_LSB   = 4;
   localparam int PATH_NEXT_LSB   = 8;

   // Reset values.
   localparam logic [VAL_W-1:0] EXPOSURE_RST = 16'h0100;
   localparam logic [VAL_W-1:0] GAIN_RST     = 16'h0001;
   localparam logic [VAL_W-1:0] IMPLIED_RST  = 16'h0200;
   localparam logic [VAL_W-1:0] FIXED_RST    = 16'h0000;

   // Trigger origins and activation kinds as stored in a path.
   localparam logic [1:0] ORG_FRAME = 2'h0;
   localparam logic [1:0] ORG_LINE0 = 2'h1;
   localparam logic [1:0] ORG_LINE1 = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_ANY  = 2'h2;
   localparam logic [1:0] EDGE_HIGH = 2'h3;

   // Direct feature indices.
   localparam int FEAT_EXPOSURE = 0;
   localparam int FEAT_GAIN     = 1;

   typedef enum logic [1:0] {PH_NORMAL, PH_CONFIG, PH_VERIFY, PH_RUN} phase_t;

   typedef struct packed {
      logic             saved;
      logic [VAL_W-1:0] exposure;
      logic [VAL_W-1:0] gain;
      logic [VAL_W-1:0] implied;
      logic [VAL_W-1:0] fixed_snap;
      logic [1:0]       origin;
      logic [1:0]       edge_kind;
      logic [SET_W-1:0] following;
   } set_entry_t;
endpackage

// [src/step_trigger_detect.sv]
// Trigger source selection and activation detection for one path.
module step_trigger_detect
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // Trigger sources
   input  wire logic       frame_begin_event,
   input  wire logic [1:0] line_in,
   // Path selection
   input  wire logic [1:0] origin,
   input  wire logic [1:0] edge_kind,
   // Result
   output logic            fire
);
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic       prev;
      logic       fire;
   } trig_state_t;

   trig_state_t st_reg;
   trig_state_t st_next;
   logic        lvl;

   always_comb
   begin
      st_next       = st_reg;
      st_next.sync1 = line_in;
      st_next.sync2 = st_reg.sync1;
      case (origin)
         ORG_FRAME: lvl = frame_begin_event;
         ORG_LINE0: lvl = st_reg.sync2[0];
         ORG_LINE1: lvl = st_reg.sync2[1];
         default:   lvl = 1'b0;
      endcase
      st_next.prev = lvl;
      case (edge_kind)
         EDGE_RISE: st_next.fire = lvl & ~st_reg.prev;
         EDGE_FALL: st_next.fire = ~lvl & st_reg.prev;
         EDGE_ANY:  st_next.fire = lvl ^ st_reg.prev;
         default:   st_next.fire = lvl;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign fire = st_reg.fire;
endmodule

// [src/acquisition_set_sequencer.sv]
// Acquisition set sequencer with APB register access and feature locking.
//
// Function
// - Entering configuration classifies features and locks fixed ones until exit.
// - Store copies current settings into selected set and flags its validity.
// - Every stored set is checked again after each store.
// - Eight sets are stored, each configured and checked separately.
// - Restore loads a valid selected set at any time.
// - Each set has exactly one path; path index must be zero.
// - A path holds trigger origin, activation kind and following set.
// - First-set register chooses the set loaded when running starts.
// - Leaving configuration checks the whole sequence and flags it.
// - Implied features are per set, writable in configuration, locked running.
// - Fixed features keep one value, locked in configuration and running.
// - Forced automatic features run off while sequencing, stay writable configuring.
// - Starting locks sequenced features and loads the first set.
// - While acquiring, the path trigger steps to the following set.
// - Unlocked features stay writable while running.
// - Stopping keeps the last active set's values.
// - Direct values are per set; the enable list covers all sets.
module acquisition_set_sequencer
   import seq_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Camera status and trigger sources
   input  wire logic              streaming,
   input  wire logic              acq_active,
   input  wire logic              frame_begin_event,
   input  wire logic [1:0]        line_in,
   // Active camera configuration
   output logic [VAL_W-1:0]       exposure_val,
   output logic [VAL_W-1:0]       gain_val,
   output logic [VAL_W-1:0]       implied_val,
   output logic [VAL_W-1:0]       fixed_val,
   output logic                   auto_drive,
   output logic [SET_W-1:0]       current_set,
   output logic                   seq_run_mode
);
   typedef struct packed {
      phase_t                       phase;
      logic [1:0]                   feat_on;
      logic                         feat_pick;
      logic                         fixed_cls;
      logic                         implied_cls;
      logic [SET_W-1:0]             set_pick;
      logic [SET_W-1:0]             first_set;
      logic [SET_W-1:0]             current_set;
      logic                         config_ok;
      logic [SET_COUNT-1:0]         set_ok;
      logic                         recheck;
      logic [VAL_W-1:0]             exposure;
      logic [VAL_W-1:0]             gain;
      logic [VAL_W-1:0]             implied;
      logic [VAL_W-1:0]             fixed;
      logic                         auto_en;
      logic                         auto_drive;
      logic                         run_flag;
      set_entry_t [SET_COUNT-1:0]   sets;
      logic                         pready;
      logic [31:0]                  prdata;
      logic                         pslverr;
   } seq_state_t;

   seq_state_t st_reg;
   seq_state_t st_next;
   logic       fire;
   set_entry_t cur_entry;

   assign cur_entry = st_reg.sets[st_reg.current_set];

   step_trigger_detect step_trigger_detect_i (
      .core_clk          (core_clk),
      .rst_b             (rst_b),
      .frame_begin_event (frame_begin_event),
      .line_in           (line_in),
      .origin            (cur_entry.origin),
      .edge_kind         (cur_entry.edge_kind),
      .fire              (fire)
   );

   // A set is usable when stored, its fixed snapshot matches and values are legal.
   function automatic logic set_check(set_entry_t e, logic [VAL_W-1:0] fixed_now);
      set_check = e.saved && (e.fixed_snap == fixed_now) && (e.exposure != '0)
                  && (e.implied >= e.exposure);
   endfunction

   // Tells whether a write to an offset is refused by the locking classes.
   function automatic logic wr_locked(logic [ADDR_W-1:0] a, phase_t ph,
                                      logic [1:0] on, logic fixed_cls);
      logic run;
      logic cfg;
      run = (ph == PH_RUN);
      cfg = (ph == PH_CONFIG) || (ph == PH_VERIFY);
      case (a)
         OFF_FEATURE:  wr_locked = run || cfg;
         OFF_PATH:     wr_locked = run;
         OFF_FIRST:    wr_locked = run;
         OFF_EXPOSURE: wr_locked = run && on[FEAT_EXPOSURE];
         OFF_GAIN:     wr_locked = run && on[FEAT_GAIN];
         OFF_IMPLIED:  wr_locked = run;
         OFF_FIXED:    wr_locked = run || (cfg && fixed_cls);
         OFF_AUTO:     wr_locked = run;
         default:      wr_locked = 1'b0;
      endcase
   endfunction

   // Copies a set's values into the active configuration.
   function automatic seq_state_t apply_set(seq_state_t s, set_entry_t e, logic [1:0] mask);
      seq_state_t t;
      t = s;
      if (mask[FEAT_EXPOSURE])
         t.exposure = e.exposure;
      if (mask[FEAT_GAIN])
         t.gain = e.gain;
      t.implied = e.implied;
      apply_set = t;
   endfunction

   always_comb
   begin
      logic             access;
      logic             commit;
      logic             known;
      logic [31:0]      rd;
      logic             all_ok;
      set_entry_t       sel;
      logic [SET_W-1:0] nxt;
      access  = psel && penable && !st_reg.pready;
      commit  = psel && penable && st_reg.pready && pwrite;
      known   = 1'b1;
      rd      = '0;
      all_ok  = 1'b0;
      nxt     = '0;
      sel     = st_reg.sets[st_reg.set_pick];
      st_next = st_reg;
      st_next.pready  = 1'b0;
      st_next.recheck = 1'b0;

      if (st_reg.recheck)
      begin
         for (int i = 0; i < SET_COUNT; i++)
            st_next.set_ok[i] = set_check(st_reg.sets[i], st_reg.fixed);
      end

      case (st_reg.phase)
         PH_VERIFY:
         begin
            all_ok = (st_reg.feat_on != 2'h0)
                     && set_check(st_reg.sets[st_reg.first_set], st_reg.fixed);
            for (int i = 0; i < SET_COUNT; i++)
            begin
               st_next.set_ok[i] = set_check(st_reg.sets[i], st_reg.fixed);
               nxt = st_reg.sets[i].following;
               if (set_check(st_reg.sets[i], st_reg.fixed)
                   && !set_check(st_reg.sets[nxt], st_reg.fixed))
                  all_ok = 1'b0;
            end
            st_next.config_ok = all_ok;
            st_next.phase     = PH_NORMAL;
         end
         PH_RUN:
         begin
            if (acq_active && fire)
            begin
               st_next.current_set = cur_entry.following;
               st_next = apply_set(st_next, st_reg.sets[cur_entry.following],
                                   st_reg.feat_on);
            end
         end
         PH_NORMAL, PH_CONFIG:
            st_next.phase = st_reg.phase;
         default:
            st_next.phase = PH_NORMAL;
      endcase

      // Read data and error answer, ready one cycle into the access phase.
      if (access)
      begin
         case (paddr)
            OFF_CTRL:
            begin
               rd[CTRL_RUN_BIT] = (st_reg.phase == PH_RUN);
               rd[CTRL_CFG_BIT] = (st_reg.phase == PH_CONFIG);
            end
            OFF_STATUS:
            begin
               rd[STAT_OK_BIT]  = st_reg.config_ok;
               rd[STAT_RUN_BIT] = (st_reg.phase == PH_RUN);
               rd[STAT_CFG_BIT] = (st_reg.phase == PH_CONFIG);
               rd[STAT_SET_LSB +: SET_W] = st_reg.current_set;
               rd[STAT_SETOK_BIT] = st_reg.set_ok[st_reg.set_pick];
            end
            OFF_FEATURE:
            begin
               rd[0] = st_reg.feat_pick;
               rd[FEAT_ON_BIT] = st_reg.feat_on[st_reg.feat_pick];
            end
            OFF_SELECT:  rd[SET_W-1:0] = st_reg.set_pick;
            OFF_SET_CMD: rd = '0;
            OFF_PATH:
            begin
               rd[1:0] = sel.origin;
               rd[PATH_EDGE_LSB +: 2] = sel.edge_kind;
               rd[PATH_NEXT_LSB +: SET_W] = sel.following;
            end
            OFF_FIRST:    rd[SET_W-1:0] = st_reg.first_set;
            OFF_EXPOSURE: rd[VAL_W-1:0] = st_reg.exposure;
            OFF_GAIN:     rd[VAL_W-1:0] = st_reg.gain;
            OFF_IMPLIED:  rd[VAL_W-1:0] = st_reg.implied;
            OFF_FIXED:    rd[VAL_W-1:0] = st_reg.fixed;
            OFF_AUTO:     rd[0] = st_reg.auto_en;
            default:      known = 1'b0;
         endcase
         st_next.pready  = 1'b1;
         st_next.prdata  = pwrite ? 32'h0000_0000 : rd;
         st_next.pslverr = !known
            || (pwrite && wr_locked(paddr, st_reg.phase, st_reg.feat_on, st_reg.fixed_cls))
            || (pwrite && (paddr == OFF_SELECT) && (pwdata[SEL_PATH_LSB +: 2] != 2'h0));
      end

      // Writes take effect at the edge that completes the transfer.
      if (commit && !st_reg.pslverr)
      begin
         case (paddr)
            OFF_CTRL:
            begin
               if (st_reg.phase == PH_NORMAL && pwdata[CTRL_CFG_BIT])
               begin
                  st_next.phase       = PH_CONFIG;
                  st_next.implied_cls = |st_reg.feat_on;
                  st_next.fixed_cls   = |st_reg.feat_on;
                  st_next.config_ok   = 1'b0;
               end
               else if (st_reg.phase == PH_NORMAL && pwdata[CTRL_RUN_BIT]
                        && st_reg.config_ok && !streaming)
               begin
                  st_next.phase       = PH_RUN;
                  st_next.current_set = st_reg.first_set;
                  st_next = apply_set(st_next, st_reg.sets[st_reg.first_set],
                                      st_reg.feat_on);
                  st_next.auto_drive  = 1'b0;
               end
               else if (st_reg.phase == PH_CONFIG && !pwdata[CTRL_CFG_BIT])
                  st_next.phase = PH_VERIFY;
               else if (st_reg.phase == PH_RUN && !pwdata[CTRL_RUN_BIT])
               begin
                  st_next.phase      = PH_NORMAL;
                  st_next.auto_drive = st_reg.auto_en;
               end
            end
            OFF_FEATURE:
            begin
               st_next.feat_pick = pwdata[0];
               st_next.feat_on[pwdata[0]] = pwdata[FEAT_ON_BIT];
            end
            OFF_SELECT: st_next.set_pick = pwdata[SET_W-1:0];
            OFF_SET_CMD:
            begin
               if (pwdata[CMD_STORE_BIT] && st_reg.phase == PH_CONFIG)
               begin
                  st_next.sets[st_reg.set_pick].saved      = 1'b1;
                  st_next.sets[st_reg.set_pick].exposure   = st_reg.exposure;
                  st_next.sets[st_reg.set_pick].gain       = st_reg.gain;
                  st_next.sets[st_reg.set_pick].implied    = st_reg.implied;
                  st_next.sets[st_reg.set_pick].fixed_snap = st_reg.fixed;
                  st_next.recheck = 1'b1;
               end
               if (pwdata[CMD_RESTORE_BIT] && st_reg.set_ok[st_reg.set_pick])
                  st_next = apply_set(st_next, sel, 2'h3);
            end
            OFF_PATH:
            begin
               st_next.sets[st_reg.set_pick].origin    = pwdata[1:0];
               st_next.sets[st_reg.set_pick].edge_kind = pwdata[PATH_EDGE_LSB +: 2];
               st_next.sets[st_reg.set_pick].following = pwdata[PATH_NEXT_LSB +: SET_W];
            end
            OFF_FIRST: st_next.first_set = pwdata[SET_W-1:0];
            OFF_EXPOSURE: st_next.exposure = pwdata[VAL_W-1:0];
            OFF_GAIN:     st_next.gain     = pwdata[VAL_W-1:0];
            OFF_IMPLIED:  st_next.implied  = pwdata[VAL_W-1:0];
            OFF_FIXED:    st_next.fixed    = pwdata[VAL_W-1:0];
            OFF_AUTO:
            begin
               st_next.auto_en    = pwdata[0];
               st_next.auto_drive = pwdata[0];
            end
            default: st_next.phase = st_next.phase;
         endcase
      end

      // The run indication is its own flop so the output needs no decoding.
      st_next.run_flag = (st_next.phase == PH_RUN);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         st_reg          <= '0;
         st_reg.phase    <= PH_NORMAL;
         st_reg.exposure <= EXPOSURE_RST;
         st_reg.gain     <= GAIN_RST;
         st_reg.implied  <= IMPLIED_RST;
         st_reg.fixed    <= FIXED_RST;
      end
      else
         st_reg <= st_next;
   end

   assign pready       = st_reg.pready;
   assign prdata       = st_reg.prdata;
   assign pslverr      = st_reg.pslverr;
   assign exposure_val = st_reg.exposure;
   assign gain_val     = st_reg.gain;
   assign implied_val  = st_reg.implied;
   assign fixed_val    = st_reg.fixed;
   assign auto_drive   = st_reg.auto_drive;
   assign current_set  = st_reg.current_set;
   assign seq_run_mode = st_reg.run_flag;
endmodule

// [tb/acquisition_set_sequencer_sva.sv]
// Port-level assertions for the acquisition set sequencer.
module acquisition_set_sequencer_sva
   import seq_pkg::*;
(
   // Clock and reset
   input wire logic              core_clk,
   input wire logic              rst_b,
   // Bus
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   // Camera
   input wire logic              streaming,
   input wire logic              acq_active,
   input wire logic [VAL_W-1:0]  exposure_val,
   input wire logic [VAL_W-1:0]  implied_val,
   input wire logic [VAL_W-1:0]  fixed_val,
   input wire logic              auto_drive,
   input wire logic [SET_W-1:0]  current_set,
   input wire logic              seq_run_mode
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite;

   property p_ready_time;
      psel && penable && !pready |=> pready;
   endproperty
   a_ready_time: assert property (p_ready_time) else $error("late bus answer");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
   property p_reset;
      disable iff (1'b0) !rst_b |=> current_set == 3'h0 && !seq_run_mode && !auto_drive
         && exposure_val == EXPOSURE_RST && implied_val == IMPLIED_RST && fixed_val == FIXED_RST;
   endproperty
   a_reset: assert property (p_reset) else $error("bad reset state");
   property p_auto_off;
      seq_run_mode && $past(seq_run_mode) |-> !auto_drive;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("auto on while running");
   property p_start;
      $rose(seq_run_mode) |-> $past(wr_done && paddr == OFF_CTRL && !streaming);
   endproperty
   a_start: assert property (p_start) else $error("run began without request");
   property p_step;
      $changed(current_set) && $past(seq_run_mode) |-> $past(acq_active);
   endproperty
   a_step: assert property (p_step) else $error("step without acquisition");
   property p_stop_keeps;
      $fell(seq_run_mode) && !$past(acq_active) |-> $stable(exposure_val) && $stable(implied_val);
   endproperty
   a_stop_keeps: assert property (p_stop_keeps) else $error("stop changed values");
   property p_fixed_lock;
      wr_done && paddr == OFF_FIXED && seq_run_mode |-> pslverr ##1 $stable(fixed_val);
   endproperty
   a_fixed_lock: assert property (p_fixed_lock) else $error("fixed written in run");
   property p_implied_lock;
      wr_done && paddr == OFF_IMPLIED && seq_run_mode |-> pslverr;
   endproperty
   a_implied_lock: assert property (p_implied_lock) else $error("implied written");
   property p_expo_cause;
      $changed(exposure_val) |-> $past(pready) || $past(seq_run_mode && acq_active);
   endproperty
   a_expo_cause: assert property (p_expo_cause) else $error("exposure changed alone");

   c_start: cover property ($rose(seq_run_mode));
   c_step: cover property ($changed(current_set) && seq_run_mode);
   c_refused: cover property (pready && pslverr);
endmodule

bind acquisition_set_sequencer acquisition_set_sequencer_sva acquisition_set_sequencer_sva_i (
   .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .streaming(streaming),
   .acq_active(acq_active), .exposure_val(exposure_val), .implied_val(implied_val),
   .fixed_val(fixed_val), .auto_drive(auto_drive), .current_set(current_set),
   .seq_run_mode(seq_run_mode));

// [tb/acquisition_set_sequencer_tb_top.sv]
// Self-checking bench for the acquisition set sequencer.
module acquisition_set_sequencer_tb_top
   import seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk = 1'b0;
   logic              rst_b = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0;
   logic              streaming = 1'b0;
   logic              acq_active = 1'b0;
   logic              frame_begin_event = 1'b0;
   logic [1:0]        line_in = 2'h0;
   logic              pready, pslverr, auto_drive, seq_run_mode;
   logic [31:0]       prdata;
   logic [VAL_W-1:0]  exposure_val, gain_val, implied_val, fixed_val;
   logic [SET_W-1:0]  current_set;
   int                n_errors = 0;
   int                compares = 0;

   always #2 core_clk = ~core_clk;

   acquisition_set_sequencer acquisition_set_sequencer_i (
      .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .streaming(streaming), .acq_active(acq_active), .frame_begin_event(frame_begin_event),
      .line_in(line_in), .exposure_val(exposure_val), .gain_val(gain_val),
      .implied_val(implied_val), .fixed_val(fixed_val), .auto_drive(auto_drive),
      .current_set(current_set), .seq_run_mode(seq_run_mode));

   task automatic complete_run();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus transfer; judges the error flag and, on reads, the data.
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         n_errors++;
         complete_run();
      end
      check(32'(pslverr), 32'(err));
      if (!w)
         check(prdata, exp);
      @(posedge core_clk);
   endtask

   task automatic wait_set(input logic [SET_W-1:0] v);
      int n;
      n = 0;
      while (current_set !== v && n < 50)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n == 50)
      begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic pulse();
      frame_begin_event <= 1'b1;
      @(posedge core_clk);
      frame_begin_event <= 1'b0;
      @(posedge core_clk);
   endtask

   function automatic logic [31:0] st(logic ok, logic run, logic cfg, logic [2:0] s, logic sok);
      return {23'h0, sok, 1'b0, s, 1'b0, cfg, run, ok};
   endfunction

   task automatic s_reset();
      check(32'(exposure_val), 32'(EXPOSURE_RST));
      check(32'({seq_run_mode, auto_drive, current_set}), 32'h0);
      xfer(1'b0, OFF_STATUS, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
   endtask

   task automatic s_config();
      logic [2:0]  sets [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
      logic [31:0] expo [4] = '{32'h10, 32'h20, 32'h300, 32'h40};
      logic [31:0] path [4] = '{32'h100, 32'h11, 32'h22, 32'h31};
      logic        ok   [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
      xfer(1'b1, OFF_FEATURE, 32'h100, 32'h0, 1'b0);
      xfer(1'b1, OFF_CTRL, 32'h2, 32'h0, 1'b0);
      xfer(1'b0, OFF_STATUS, 32'h0, st(1'b0, 1'b0, 1'b1, 3'h0, 1'b0), 1'b0);
      xfer(1'b1, OFF_FIXED, 32'h5, 32'h0, 1'b1);
      check(32'(fixed_val), 32'(FIXED_RST));
      xfer(1'b1, OFF_FEATURE, 32'h101, 32'h0, 1'b1);
      xfer(1'b1, OFF_SELECT, 32'h100, 32'h0, 1'b1);
      xfer(1'b1, OFF_AUTO, 32'h1, 32'h0, 1'b0);
      check(32'(auto_drive), 32'h1);
      xfer(1'b1, OFF_IMPLIED, 32'h280, 32'h0, 1'b0);
      check(32'(implied_val), 32'h280);
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, OFF_SELECT, 32'(sets[i]), 32'h0, 1'b0);
         xfer(1'b1, OFF_EXPOSURE, expo[i], 32'h0, 1'b0);
         xfer(1'b1, OFF_PATH, path[i], 32'h0, 1'b0);
         xfer(1'b1, OFF_SET_CMD, 32'h1, 32'h0, 1'b0);
         xfer(1'b0, OFF_STATUS, 32'h0, st(1'b0, 1'b0, 1'b1, 3'h0, ok[i]), 1'b0);
      end
      xfer(1'b0, OFF_PATH, 32'h0, 32'h31, 1'b0);
      xfer(1'b1, OFF_FIRST, 32'h0, 32'h0, 1'b0);
      xfer(1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0);
      xfer(1'b0, OFF_STATUS, 32'h0, st(1'b1, 1'b0, 1'b0, 3'h0, 1'b1), 1'b0);
   endtask

   task automatic s_restore();
      xfer(1'b1, OFF_SELECT, 32'h1, 32'h0, 1'b0);
      xfer(1'b1, OFF_SET_CMD, 32'h2, 32'h0, 1'b0);
      check(32'(exposure_val), 32'h20);
      xfer(1'b1, OFF_SELECT, 32'h2, 32'h0, 1'b0);
      xfer(1'b1, OFF_SET_CMD, 32'h2, 32'h0, 1'b0);
      check(32'(exposure_val), 32'h20);
   endtask

   task automatic s_run();
      logic [ADDR_W-1:0] locked [7] = '{OFF_EXPOSURE, OFF_IMPLIED, OFF_FIXED, OFF_AUTO,
                                        OFF_PATH, OFF_FIRST, OFF_FEATURE};
      streaming <= 1'b1;
      xfer(1'b1, OFF_CTRL, 32'h1, 32'h0, 1'b0);
      check(32'(seq_run_mode), 32'h0);
      streaming <= 1'b0;
      xfer(1'b1, OFF_CTRL, 32'h1, 32'h0, 1'b0);
      check(32'(seq_run_mode), 32'h1);
      check(32'(exposure_val), 32'h10);
      check(32'(auto_drive), 32'h0);
      for (int i = 0; i < 7; i++)
         xfer(1'b1, locked[i], 32'h1, 32'h0, 1'b1);
      xfer(1'b1, OFF_GAIN, 32'h5, 32'h0, 1'b0);
      check(32'(gain_val), 32'h5);
   endtask

   task automatic s_step();
      acq_active <= 1'b1;
      pulse();
      wait_set(3'h1);
      check(32'(exposure_val), 32'h20);
      xfer(1'b0, OFF_STATUS, 32'h0, st(1'b1, 1'b1, 1'b0, 3'h1, 1'b0), 1'b0);
      pulse();
      line_in <= 2'h1;
      repeat (6) @(posedge core_clk);
      check(32'(current_set), 32'h1);
      line_in <= 2'h0;
      wait_set(3'h0);
      check(32'(exposure_val), 32'h10);
      acq_active <= 1'b0;
      pulse();
      repeat (10) @(posedge core_clk);
      check(32'(current_set), 32'h0);
   endtask

   task automatic s_stop();
      xfer(1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0);
      check(32'(seq_run_mode), 32'h0);
      check(32'(exposure_val), 32'h10);
      check(32'(auto_drive), 32'h1);
   endtask

   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      s_reset();
      s_config();
      s_restore();
      s_run();
      s_step();
      s_stop();
      complete_run();
   end
endmodule
